// file: agomr_osc_src.sv
// oscillator source: frames bursts of oscillator edges at the link rate
`timescale 1ns/1ps
`default_nettype none
module agomr_osc_src (
  // burst request
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] edges,
  // oscillator side
  output logic            osc_in,
  output logic            osc_burst_run,
  output logic            busy
);
  // oscillator stands still between bursts, 200 ns period inside them
  initial begin
    osc_in = 1'b0;
    osc_burst_run = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        osc_burst_run <= 1'b1;
        #37;
        repeat (edges) begin
          osc_in = 1'b1;
          #100;
          osc_in = 1'b0;
          #100;
        end
        repeat (8) @(posedge clk);
        osc_burst_run <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule : agomr_osc_src
`default_nettype wire

// file: agomr_pkg.sv
// package: offsets, fields, resets and codes of the gain and output mode registers
`default_nettype none
package agomr_pkg;
  // register offsets
  localparam logic [7:0] CHAN0_GAIN_LOW_OFS   = 8'h1c;
  localparam logic [7:0] CHAN0_GAIN_HIGH_OFS  = 8'h1d;
  localparam logic [7:0] CHAN1_GAIN_LOW_OFS   = 8'h1e;
  localparam logic [7:0] CHAN1_GAIN_HIGH_OFS  = 8'h1f;
  localparam logic [7:0] OUTPUT_FMT_CTRL_OFS  = 8'h20;
  localparam logic [7:0] INT_OSC_CTRL_OFS     = 8'h21;
  localparam logic [7:0] TEST_PAT_BYTE0_OFS   = 8'h23;
  localparam logic [7:0] TEST_PAT_BYTE1_OFS   = 8'h24;
  localparam logic [7:0] TEST_PAT_BYTE2_OFS   = 8'h25;
  localparam logic [7:0] TEST_PAT_BYTE3_OFS   = 8'h26;
  // reset values
  localparam logic [7:0] GAIN_LOW_RST         = 8'h00;
  localparam logic [7:0] GAIN_HIGH_RST        = 8'h80;
  localparam logic [7:0] OUTPUT_FMT_CTRL_RST  = 8'h00;
  localparam logic [1:0] FREQ_DIV_RST         = 2'h0;
  localparam logic [5:0] PULSE_LIMIT_RST      = 6'h00;
  localparam logic [7:0] TEST_PAT_BYTE0_RST   = 8'h0f;
  localparam logic [7:0] TEST_PAT_BYTE1_RST   = 8'h0f;
  localparam logic [7:0] TEST_PAT_BYTE2_RST   = 8'h5a;
  localparam logic [7:0] TEST_PAT_BYTE3_RST   = 8'h5a;
  // field positions in output_format_control
  localparam int LANE_SEL_LSB   = 6;
  localparam int CLK_SEL_LSB    = 4;
  localparam int DDR_BIT        = 3;
  localparam int FMT_SEL_LSB    = 0;
  // field positions in internal_osc_control
  localparam int PULSE_LIMIT_LSB = 2;
  localparam int FREQ_DIV_LSB    = 0;
  // gain scaling: unity word is 2^15
  localparam logic [15:0] GAIN_UNITY = 16'h8000;
  localparam int          GAIN_SHIFT = 15;
  typedef enum logic [1:0] {
    AGOMR_LANE_ONE   = 2'b00,
    AGOMR_LANE_TWO   = 2'b01,
    AGOMR_LANE_FOUR  = 2'b10,
    AGOMR_LANE_INTLV = 2'b11
  } agomr_lane_t;
  typedef enum logic [1:0] {
    AGOMR_CLK_HOST   = 2'b00,
    AGOMR_CLK_ECHO   = 2'b01,
    AGOMR_CLK_MASTER = 2'b10,
    AGOMR_CLK_BAD    = 2'b11
  } agomr_clk_t;
  typedef enum logic [2:0] {
    AGOMR_FMT_D24     = 3'b000,
    AGOMR_FMT_D16_CM8 = 3'b001,
    AGOMR_FMT_D24_CM8 = 3'b010,
    AGOMR_FMT_AVG30   = 3'b011,
    AGOMR_FMT_PATTERN = 3'b100
  } agomr_fmt_t;
  // output word sizes in bits
  localparam logic [6:0] WORD_BITS_24 = 7'd24;
  localparam logic [6:0] WORD_BITS_32 = 7'd32;
  // oscillator divider codes
  localparam logic [1:0] FREQ_DIV_1 = 2'b00;
  localparam logic [1:0] FREQ_DIV_2 = 2'b01;
  localparam logic [1:0] FREQ_DIV_4 = 2'b10;
endpackage : agomr_pkg
`default_nettype wire

// file: agomr_regs.sv
// gain and output mode register bank with per-channel gain, word formatting and oscillator gate
//
// Function
// [R01] each channel result is multiplied by its unsigned 16-bit gain word and divided by 0x8000.
// [R02] gain word 0xffff gives the largest gain, 0xffff/0x8000 = 1.99997.
// [R03] both gain words reset to high byte 0x80 and low byte 0x00, which is unity gain.
// [R04] lane select 00, 01, 10 gives one, two or four lanes per channel.
// [R05] lane select 11 interleaves both channels on the first data lane.
// [R06] clocking select 00 host, 01 echo, 10 device master; the host never writes 11.
// [R07] bit 3 picks single (0) or double (1) data rate; double only with echo or master clock.
// [R08] format 000 is 24-bit diff, 001 is 16-bit diff plus 8-bit cm, 010 is 24-bit diff plus cm.
// [R09] format 011 is a 30-bit averaged result followed by an overrange and a sync bit.
// [R10] format 100 sends the 32-bit test pattern instead of conversion data.
// [R11] the read-only pulse limit caps each oscillator burst at the limit plus one pulses.
// [R12] the pulse limit is computed from word size, active lanes and data rate.
// [R13] the oscillator divider divides by 1, 2 or 4 for codes 00, 01, 10.
// [R14] the 32-bit test pattern held in four byte registers is applied to both channels.
// [R15] the host never writes format codes 101 to 111 or divider code 11.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// one channel: gain multiply and output word formatting
module agomr_chan
  import agomr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // conversion inputs
  input  wire logic        sample_valid,
  input  wire logic [23:0] diff_in,
  input  wire logic [7:0]  cm_in,
  input  wire logic [29:0] avg_in,
  input  wire logic        ovr_in,
  input  wire logic        sync_in,
  // configuration
  input  wire logic [15:0] gain_word,
  input  wire logic [2:0]  fmt_sel,
  input  wire logic [31:0] pattern,
  // formatted output
  output logic [31:0]      word_ff,
  output logic             word_valid_ff
);
  import agomr_pkg::*;

  logic signed [40:0] prod;
  logic signed [25:0] scaled;
  logic               fits;
  logic        [23:0] gained;
  logic        [31:0] nxt_word;

  assign prod   = $signed(diff_in) * $signed({1'b0, gain_word}); // R01 R02
  assign scaled = prod[40:GAIN_SHIFT]; // R01
  assign fits   = (scaled[25:23] == 3'b000) || (scaled[25:23] == 3'b111);
  assign gained = fits ? scaled[23:0] : (scaled[25] ? 24'h800000 : 24'h7fffff); // R02

  always_comb begin
    unique case (agomr_fmt_t'(fmt_sel))
      AGOMR_FMT_D24:     nxt_word = {gained, 8'h00}; // R08
      AGOMR_FMT_D16_CM8: nxt_word = {gained[23:8], cm_in, 8'h00}; // R08
      AGOMR_FMT_D24_CM8: nxt_word = {gained, cm_in}; // R08
      AGOMR_FMT_AVG30:   nxt_word = {avg_in, ovr_in, sync_in}; // R09
      AGOMR_FMT_PATTERN: nxt_word = pattern; // R10 R14
      default:           nxt_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      word_ff       <= 32'h00000000;
      word_valid_ff <= 1'b0;
    end else begin
      word_valid_ff <= sample_valid;
      if (sample_valid) begin
        word_ff <= nxt_word;
      end
    end
  end
endmodule : agomr_chan

////////////////////////////////////////////////////////////////////////////////
// top: register bank, pulse limit, oscillator divider and burst gate
module agomr_regs
  import agomr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata_ff,
  // channel 0 conversion inputs
  input  wire logic        chan0_valid,
  input  wire logic [23:0] chan0_diff,
  input  wire logic [7:0]  chan0_cm,
  input  wire logic [29:0] chan0_avg,
  input  wire logic        chan0_ovr,
  input  wire logic        chan0_sync,
  // channel 1 conversion inputs
  input  wire logic        chan1_valid,
  input  wire logic [23:0] chan1_diff,
  input  wire logic [7:0]  chan1_cm,
  input  wire logic [29:0] chan1_avg,
  input  wire logic        chan1_ovr,
  input  wire logic        chan1_sync,
  // formatted words
  output logic [31:0]      chan0_word_ff,
  output logic             chan0_word_valid_ff,
  output logic [31:0]      chan1_word_ff,
  output logic             chan1_word_valid_ff,
  // decoded serial output mode
  output logic [2:0]       lanes_per_chan_ff,
  output logic             interleave_ff,
  output logic [1:0]       clocking_select_ff,
  output logic             double_rate_enable_ff,
  output logic [2:0]       output_format_select_ff,
  // internal oscillator
  input  wire logic        osc_in,
  input  wire logic        osc_burst_run,
  output logic             osc_tick_ff,
  output logic [5:0]       osc_pulse_limit_ff
);
  import agomr_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [15:0] chan0_gain_word_ff;
  logic [15:0] chan1_gain_word_ff;
  logic [7:0]  mode_ff;
  logic [1:0]  osc_freq_divider_ff;
  logic [31:0] test_pattern_word_ff;
  logic wr_g0l, wr_g0h, wr_g1l, wr_g1h, wr_mode, wr_osc;
  logic wr_p0, wr_p1, wr_p2, wr_p3;

  assign wr_g0l  = reg_wr && (reg_addr == CHAN0_GAIN_LOW_OFS);
  assign wr_g0h  = reg_wr && (reg_addr == CHAN0_GAIN_HIGH_OFS);
  assign wr_g1l  = reg_wr && (reg_addr == CHAN1_GAIN_LOW_OFS);
  assign wr_g1h  = reg_wr && (reg_addr == CHAN1_GAIN_HIGH_OFS);
  assign wr_mode = reg_wr && (reg_addr == OUTPUT_FMT_CTRL_OFS);
  assign wr_osc  = reg_wr && (reg_addr == INT_OSC_CTRL_OFS);
  assign wr_p0   = reg_wr && (reg_addr == TEST_PAT_BYTE0_OFS);
  assign wr_p1   = reg_wr && (reg_addr == TEST_PAT_BYTE1_OFS);
  assign wr_p2   = reg_wr && (reg_addr == TEST_PAT_BYTE2_OFS);
  assign wr_p3   = reg_wr && (reg_addr == TEST_PAT_BYTE3_OFS);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chan0_gain_word_ff <= {GAIN_HIGH_RST, GAIN_LOW_RST}; // R03
      chan1_gain_word_ff <= {GAIN_HIGH_RST, GAIN_LOW_RST}; // R03
    end else begin
      if (wr_g0l) chan0_gain_word_ff[7:0]  <= reg_wdata;
      if (wr_g0h) chan0_gain_word_ff[15:8] <= reg_wdata;
      if (wr_g1l) chan1_gain_word_ff[7:0]  <= reg_wdata;
      if (wr_g1h) chan1_gain_word_ff[15:8] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_ff             <= OUTPUT_FMT_CTRL_RST;
      osc_freq_divider_ff <= FREQ_DIV_RST;
    end else begin
      if (wr_mode) mode_ff <= reg_wdata;
      if (wr_osc) osc_freq_divider_ff <= reg_wdata[FREQ_DIV_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      test_pattern_word_ff <= {TEST_PAT_BYTE3_RST, TEST_PAT_BYTE2_RST,
                               TEST_PAT_BYTE1_RST, TEST_PAT_BYTE0_RST};
    end else begin
      if (wr_p0) test_pattern_word_ff[7:0]   <= reg_wdata;
      if (wr_p1) test_pattern_word_ff[15:8]  <= reg_wdata;
      if (wr_p2) test_pattern_word_ff[23:16] <= reg_wdata;
      if (wr_p3) test_pattern_word_ff[31:24] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path, data in the cycle after the strobe
  logic [7:0] rd_mux;

  assign rd_mux =
    (reg_addr == CHAN0_GAIN_LOW_OFS)  ? chan0_gain_word_ff[7:0]    :
    (reg_addr == CHAN0_GAIN_HIGH_OFS) ? chan0_gain_word_ff[15:8]   :
    (reg_addr == CHAN1_GAIN_LOW_OFS)  ? chan1_gain_word_ff[7:0]    :
    (reg_addr == CHAN1_GAIN_HIGH_OFS) ? chan1_gain_word_ff[15:8]   :
    (reg_addr == OUTPUT_FMT_CTRL_OFS) ? mode_ff                    :
    (reg_addr == INT_OSC_CTRL_OFS)    ? {osc_pulse_limit_ff, osc_freq_divider_ff} : // R11
    (reg_addr == TEST_PAT_BYTE0_OFS)  ? test_pattern_word_ff[7:0]  :
    (reg_addr == TEST_PAT_BYTE1_OFS)  ? test_pattern_word_ff[15:8] :
    (reg_addr == TEST_PAT_BYTE2_OFS)  ? test_pattern_word_ff[23:16] :
    (reg_addr == TEST_PAT_BYTE3_OFS)  ? test_pattern_word_ff[31:24] :
    8'h00;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode
  logic [1:0] lane_select;
  logic [1:0] clocking_select;
  logic       double_rate_enable;
  logic [2:0] output_format_select;
  logic [2:0] nxt_lanes;
  logic [1:0] lane_shift;
  logic       nxt_intlv;

  assign lane_select          = mode_ff[LANE_SEL_LSB +: 2];
  assign clocking_select      = mode_ff[CLK_SEL_LSB +: 2]; // R06
  assign double_rate_enable   = mode_ff[DDR_BIT]; // R07
  assign output_format_select = mode_ff[FMT_SEL_LSB +: 3];

  always_comb begin
    unique case (agomr_lane_t'(lane_select))
      AGOMR_LANE_ONE: begin
        nxt_lanes  = 3'd1; // R04
        lane_shift = 2'd0;
        nxt_intlv  = 1'b0;
      end
      AGOMR_LANE_TWO: begin
        nxt_lanes  = 3'd2; // R04
        lane_shift = 2'd1;
        nxt_intlv  = 1'b0;
      end
      AGOMR_LANE_FOUR: begin
        nxt_lanes  = 3'd4; // R04
        lane_shift = 2'd2;
        nxt_intlv  = 1'b0;
      end
      AGOMR_LANE_INTLV: begin
        nxt_lanes  = 3'd1; // R05
        lane_shift = 2'd0;
        nxt_intlv  = 1'b1; // R05
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lanes_per_chan_ff       <= 3'd1;
      interleave_ff           <= 1'b0;
      clocking_select_ff      <= 2'b00;
      double_rate_enable_ff   <= 1'b0;
      output_format_select_ff <= 3'b000;
    end else begin
      lanes_per_chan_ff       <= nxt_lanes;
      interleave_ff           <= nxt_intlv;
      clocking_select_ff      <= clocking_select; // R06
      double_rate_enable_ff   <= double_rate_enable; // R07
      output_format_select_ff <= output_format_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pulse limit: clocks per frame minus one
  logic [6:0] word_bits;
  logic [7:0] frame_bits;
  logic [7:0] frame_clks;
  logic [5:0] nxt_limit;

  assign word_bits  = (output_format_select == AGOMR_FMT_D24 ||
                       output_format_select == AGOMR_FMT_D16_CM8) ?
                      WORD_BITS_24 : WORD_BITS_32; // R12
  assign frame_bits = nxt_intlv ? {word_bits, 1'b0} : {1'b0, word_bits}; // R12
  assign frame_clks = frame_bits >> (lane_shift + {1'b0, double_rate_enable}); // R12
  assign nxt_limit  = 6'(frame_clks - 8'd1); // R12

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_pulse_limit_ff <= PULSE_LIMIT_RST;
    end else begin
      osc_pulse_limit_ff <= nxt_limit; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // oscillator: synchronise, divide, gate the burst
  logic       osc_s1_ff;
  logic       osc_s2_ff;
  logic       osc_s3_ff;
  logic [1:0] div_cnt_ff;
  logic [6:0] burst_cnt_ff;
  logic       osc_rise;
  logic       div_hit;
  logic       burst_open;
  logic [1:0] div_max;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      osc_s1_ff <= osc_in;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  assign osc_rise   = osc_s2_ff && !osc_s3_ff;
  assign div_max    = (osc_freq_divider_ff == FREQ_DIV_4) ? 2'd3 :
                      (osc_freq_divider_ff == FREQ_DIV_2) ? 2'd1 : 2'd0; // R13
  assign div_hit    = osc_rise && (div_cnt_ff == div_max); // R13
  assign burst_open = osc_burst_run && (burst_cnt_ff <= {1'b0, osc_pulse_limit_ff}); // R11

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_cnt_ff   <= 2'd0;
      burst_cnt_ff <= 7'd0;
      osc_tick_ff  <= 1'b0;
    end else begin
      if (!osc_burst_run) begin
        div_cnt_ff <= 2'd0;
      end else if (osc_rise) begin
        div_cnt_ff <= (div_cnt_ff == div_max) ? 2'd0 : div_cnt_ff + 2'd1; // R13
      end
      if (!osc_burst_run) begin
        burst_cnt_ff <= 7'd0;
      end else if (div_hit && burst_open) begin
        burst_cnt_ff <= burst_cnt_ff + 7'd1; // R11
      end
      osc_tick_ff <= div_hit && burst_open; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channels
  agomr_chan u_chan0 (
    .clk           (clk),
    .rst_b         (rst_b),
    .sample_valid  (chan0_valid),
    .diff_in       (chan0_diff),
    .cm_in         (chan0_cm),
    .avg_in        (chan0_avg),
    .ovr_in        (chan0_ovr),
    .sync_in       (chan0_sync),
    .gain_word     (chan0_gain_word_ff),
    .fmt_sel       (output_format_select),
    .pattern       (test_pattern_word_ff),
    .word_ff       (chan0_word_ff),
    .word_valid_ff (chan0_word_valid_ff)
  );
  agomr_chan u_chan1 (
    .clk           (clk),
    .rst_b         (rst_b),
    .sample_valid  (chan1_valid),
    .diff_in       (chan1_diff),
    .cm_in         (chan1_cm),
    .avg_in        (chan1_avg),
    .ovr_in        (chan1_ovr),
    .sync_in       (chan1_sync),
    .gain_word     (chan1_gain_word_ff),
    .fmt_sel       (output_format_select),
    .pattern       (test_pattern_word_ff),
    .word_ff       (chan1_word_ff),
    .word_valid_ff (chan1_word_valid_ff)
  );
endmodule : agomr_regs
`default_nettype wire

// file: agomr_regs_checker.sv
// checker: port relations of the gain and output mode register bank
`timescale 1ns/1ps
`default_nettype none
module agomr_regs_checker
  import agomr_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata_ff,
  // channels
  input wire logic        chan0_valid,
  input wire logic        chan1_valid,
  input wire logic [31:0] chan0_word_ff,
  input wire logic        chan0_word_valid_ff,
  input wire logic [31:0] chan1_word_ff,
  // mode outputs
  input wire logic [2:0]  lanes_per_chan_ff,
  input wire logic        interleave_ff,
  input wire logic [1:0]  clocking_select_ff,
  input wire logic        double_rate_enable_ff,
  input wire logic [2:0]  output_format_select_ff,
  // oscillator
  input wire logic        osc_burst_run,
  input wire logic        osc_tick_ff,
  input wire logic [5:0]  osc_pulse_limit_ff
);
  logic [7:0] wd_ff, wd2_ff;
  logic [2:0] quiet_ff, exp_lanes;
  logic [6:0] tick_cnt_ff, word_bits, exp_bits;
  logic [1:0] lane_log;
  logic [5:0] exp_limit;
  logic       mode_wr;
  assign mode_wr = reg_wr && (reg_addr == OUTPUT_FMT_CTRL_OFS);
  assign exp_lanes = (wd2_ff[7:6] == 2'b11) ? 3'd1 : (3'd1 << wd2_ff[7:6]);
  assign word_bits = (output_format_select_ff < 3'd2) ? WORD_BITS_24 : WORD_BITS_32;
  assign exp_bits = interleave_ff ? {word_bits[5:0], 1'b0} : word_bits;
  assign lane_log = lanes_per_chan_ff[2] ? 2'd2 : {1'b0, lanes_per_chan_ff[1]};
  assign exp_limit = 6'((exp_bits >> (lane_log + {1'b0, double_rate_enable_ff})) - 7'd1);
  always_ff @(posedge clk) begin
    wd_ff <= reg_wdata;
    wd2_ff <= wd_ff;
    if (!rst_b || mode_wr) quiet_ff <= 3'd0;
    else if (quiet_ff != 3'd4) quiet_ff <= quiet_ff + 3'd1;
    if (!rst_b || !osc_burst_run) tick_cnt_ff <= 7'd0;
    else if (osc_tick_ff) tick_cnt_ff <= tick_cnt_ff + 7'd1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_lane_sel; mode_wr |-> ##2 lanes_per_chan_ff == exp_lanes; endproperty
  property p_intlv; mode_wr |-> ##2 interleave_ff == (wd2_ff[7:6] == 2'b11); endproperty
  property p_clk_sel; mode_wr |-> ##2 clocking_select_ff == wd2_ff[5:4]; endproperty
  property p_ddr; mode_wr |-> ##2 double_rate_enable_ff == wd2_ff[3]; endproperty
  property p_fmt_sel; mode_wr |-> ##2 output_format_select_ff == wd2_ff[2:0]; endproperty
  property p_low_byte;
    chan0_valid && output_format_select_ff == 3'b000 && quiet_ff == 3'd4
      |=> chan0_word_valid_ff && chan0_word_ff[7:0] == 8'h00;
  endproperty
  property p_pat_both;
    chan0_valid && chan1_valid && output_format_select_ff == 3'b100 && quiet_ff == 3'd4
      |=> chan0_word_ff == chan1_word_ff;
  endproperty
  property p_limit_calc; quiet_ff == 3'd4 |-> osc_pulse_limit_ff == exp_limit; endproperty
  property p_limit_reg;
    reg_rd && reg_addr == INT_OSC_CTRL_OFS && quiet_ff == 3'd4
      |=> reg_rdata_ff[7:2] == osc_pulse_limit_ff;
  endproperty
  property p_tick_cap;
    osc_burst_run |-> tick_cnt_ff <= 7'(osc_pulse_limit_ff) + 7'd1;
  endproperty
  a_lane_sel: assert property (p_lane_sel) else $error("lane count wrong");
  a_intlv: assert property (p_intlv) else $error("interleave wrong");
  a_clk_sel: assert property (p_clk_sel) else $error("clocking select wrong");
  a_ddr: assert property (p_ddr) else $error("data rate wrong");
  a_fmt_sel: assert property (p_fmt_sel) else $error("format select wrong");
  a_low_byte: assert property (p_low_byte) else $error("24-bit word low byte wrong");
  a_pat_both: assert property (p_pat_both) else $error("channels differ in pattern");
  a_limit_calc: assert property (p_limit_calc) else $error("pulse limit wrong");
  a_limit_reg: assert property (p_limit_reg) else $error("limit field wrong");
  a_tick_cap: assert property (p_tick_cap) else $error("burst exceeds limit");
  c_intlv: cover property (mode_wr && reg_wdata[7:6] == 2'b11);
  c_pattern: cover property (chan0_valid && output_format_select_ff == 3'b100);
  c_cap: cover property (tick_cnt_ff == 7'(osc_pulse_limit_ff) + 7'd1);
endmodule : agomr_regs_checker
bind agomr_regs agomr_regs_checker u_chk (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .chan0_valid(chan0_valid),
  .chan1_valid(chan1_valid), .chan0_word_ff(chan0_word_ff),
  .chan0_word_valid_ff(chan0_word_valid_ff), .chan1_word_ff(chan1_word_ff),
  .lanes_per_chan_ff(lanes_per_chan_ff), .interleave_ff(interleave_ff),
  .clocking_select_ff(clocking_select_ff), .double_rate_enable_ff(double_rate_enable_ff),
  .output_format_select_ff(output_format_select_ff), .osc_burst_run(osc_burst_run),
  .osc_tick_ff(osc_tick_ff), .osc_pulse_limit_ff(osc_pulse_limit_ff));
`default_nettype wire

// file: agomr_regs_tb.sv
// testbench: registers, word formats, mode outputs and oscillator bursts
`timescale 1ns/1ps
`default_nettype none
module agomr_regs_tb;
  import agomr_pkg::*;
  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] gain;
    logic [23:0] diff;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [5:0]  lim;
  } agomr_row_t;
  logic        clk, rst_b, reg_wr, reg_rd, valid, ovr, sync, go, busy;
  logic        osc_in, run, wv0, wv1, tick, intlv, ddr;
  logic [7:0]  reg_addr, reg_wdata, rdata, cm, edges;
  logic [23:0] diff;
  logic [29:0] avg;
  logic [31:0] w0, w1;
  logic [2:0]  lanes, fmt;
  logic [1:0]  csel;
  logic [5:0]  lim;
  int          mismatches, cmp_count, ticks, k;
  int          osc_n [3] = '{30, 20, 20};
  int          osc_t [3] = '{24, 10, 5};
  logic [7:0]  rst_a [10] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h23, 8'h24,
                              8'h25, 8'h26};
  logic [7:0]  rst_d [10] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h5c, 8'h0f, 8'h0f,
                              8'h5a, 8'h5a};
  agomr_row_t  rows [7] = '{
    '{8'h00, 16'h8000, 24'h000100, 32'h00010000, 32'h00010000, 6'h17},
    '{8'h41, 16'h8000, 24'h123456, 32'h1234a500, 32'h1234a500, 6'h0b},
    '{8'h9a, 16'h4000, 24'h000200, 32'h000100a5, 32'h000200a5, 6'h03},
    '{8'he3, 16'h8000, 24'h000100, 32'h048d159e, 32'h048d159e, 6'h3f},
    '{8'h24, 16'h8000, 24'h000100, 32'h5a5a0f0f, 32'h5a5a0f0f, 6'h1f},
    '{8'h00, 16'hffff, 24'h000100, 32'h0001ff00, 32'h00010000, 6'h17},
    '{8'h00, 16'h4000, 24'hffff00, 32'hffff8000, 32'hffff0000, 6'h17}};
  agomr_regs DUT (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
    .chan0_valid(valid), .chan0_diff(diff), .chan0_cm(cm), .chan0_avg(avg),
    .chan0_ovr(ovr), .chan0_sync(sync),
    .chan1_valid(valid), .chan1_diff(diff), .chan1_cm(cm), .chan1_avg(avg),
    .chan1_ovr(ovr), .chan1_sync(sync),
    .chan0_word_ff(w0), .chan0_word_valid_ff(wv0), .chan1_word_ff(w1),
    .chan1_word_valid_ff(wv1), .lanes_per_chan_ff(lanes), .interleave_ff(intlv),
    .clocking_select_ff(csel), .double_rate_enable_ff(ddr), .output_format_select_ff(fmt),
    .osc_in(osc_in), .osc_burst_run(run), .osc_tick_ff(tick), .osc_pulse_limit_ff(lim));
  agomr_osc_src u_osc (
    .clk(clk), .go(go), .edges(edges), .osc_in(osc_in), .osc_burst_run(run), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr
  task automatic idle(input int n);
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (n - 1) @(posedge clk);
  endtask : idle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({24'h0, rdata}, {24'h0, exp}, "read");
  endtask : rd
  task automatic fire(input logic [23:0] d);
    @(posedge clk);
    reg_wr <= 1'b0;
    diff <= d;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    #1;
    chk({31'h0, wv0 & wv1}, 32'h1, "word valid");
  endtask : fire
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (tick === 1'b1) ticks = ticks + 1;
  initial begin
    #500000;
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    valid = 1'b0;
    diff = 24'h0;
    cm = 8'ha5;
    avg = 30'h1234567;
    ovr = 1'b1;
    sync = 1'b0;
    go = 1'b0;
    edges = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    idle(4);
    foreach (rows[i]) begin
      wr(OUTPUT_FMT_CTRL_OFS, rows[i].mode);
      wr(CHAN0_GAIN_HIGH_OFS, rows[i].gain[15:8]);
      wr(CHAN0_GAIN_LOW_OFS, rows[i].gain[7:0]);
      idle(4);
      fire(rows[i].diff);
      chk(w0, rows[i].w0, "chan0 word");
      chk(w1, rows[i].w1, "chan1 word");
      chk({29'h0, lanes}, (rows[i].mode[7:6] == 2'b11) ? 32'h1 : 32'h1 << rows[i].mode[7:6],
          "lanes");
      chk({31'h0, intlv}, {31'h0, rows[i].mode[7:6] == 2'b11}, "interleave");
      chk({26'h0, csel, ddr, fmt}, {26'h0, rows[i].mode[5:0]}, "mode fields");
      chk({26'h0, lim}, {26'h0, rows[i].lim}, "pulse limit");
      rd(INT_OSC_CTRL_OFS, {rows[i].lim, 2'b00});
    end
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    rd(8'h22, 8'h00);
    wr(INT_OSC_CTRL_OFS, 8'hfd);
    rd(INT_OSC_CTRL_OFS, 8'h5d);
    wr(TEST_PAT_BYTE0_OFS, 8'h11);
    wr(TEST_PAT_BYTE1_OFS, 8'h22);
    wr(TEST_PAT_BYTE2_OFS, 8'h33);
    wr(TEST_PAT_BYTE3_OFS, 8'h44);
    wr(OUTPUT_FMT_CTRL_OFS, 8'h04);
    idle(4);
    fire(24'h000100);
    chk(w0, 32'h44332211, "pattern chan0");
    chk(w1, 32'h44332211, "pattern chan1");
    wr(OUTPUT_FMT_CTRL_OFS, 8'h00);
    wr(CHAN1_GAIN_HIGH_OFS, 8'h40);
    wr(CHAN1_GAIN_LOW_OFS, 8'h01);
    idle(4);
    fire(24'h010000);
    chk(w0, 32'h00800000, "chan0 gain");
    chk(w1, 32'h00800200, "chan1 gain");
    for (int b = 0; b < 3; b++) begin
      wr(INT_OSC_CTRL_OFS, {6'h00, 2'(b)});
      idle(4);
      ticks = 0;
      edges <= 8'(osc_n[b]);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
      for (k = 0; k < 4000 && busy === 1'b1; k++) @(posedge clk);
      chk(ticks, osc_t[b], "oscillator ticks");
    end
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    idle(4);
    for (k = 0; k < 10; k++) rd(rst_a[k], rst_d[k]);
    end_of_test();
  end
endmodule : agomr_regs_tb
`default_nettype wire
